//--- src/remote_encoder_consts.svh
// constants of the four key remote encoder
`ifndef REMOTE_ENCODER_CONSTS_SVH
`define REMOTE_ENCODER_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define SLOT_TIME_NS 111000
`define ADDR_BITS 8
`define DATA_BITS 4
`define FRAME_BITS 12
`define FRAMES_PER_BURST 3'h5
`define PILOT_SLOTS 6'h24
`define SLOTS_PER_BIT 6'h3
`define DEVICE_ADDR 8'ha5
`define NIBBLE_KEY1 4'h1
`define NIBBLE_KEY2 4'h2
`define NIBBLE_KEY3 4'h4
`define NIBBLE_KEY4 4'h8

`endif

//--- src/remote_encoder_pkg.sv
// types of the four key remote encoder
`default_nettype none
package remote_encoder_pkg;

    typedef enum logic [1:0] {
        IDLE,
        PILOT,
        SYNC,
        DATA
    } phase_t;

    typedef struct packed {
        logic [3:0] keyMeta;
        logic [3:0] keySync;
        logic [3:0] keyPrev;
        phase_t phase;
        logic [31:0] divCnt;
        logic [5:0] slotCnt;
        logic [3:0] bitIdx;
        logic [2:0] frameCnt;
        logic [11:0] frameWord;
        logic serialOut;
        logic txPower;
    } enc_state_t;

endpackage
`default_nettype wire

//--- src/oneshot_four_key_remote_encoder.sv
// four key one-shot serial remote encoder
`timescale 1ns/10ps
`default_nettype none
`include "remote_encoder_consts.svh"

module oneshot_four_key_remote_encoder
    import remote_encoder_pkg::*;
#(
    parameter int SlotCycles = (`SLOT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // push buttons
    input wire logic key_in_1,
    input wire logic key_in_2,
    input wire logic key_in_3,
    input wire logic key_in_4,
    // serial line
    output logic serialOut,
    // radio power
    output logic radio_tx_power,
    output logic radio_rx_power
);

    localparam enc_state_t StateReset = '{
        keyMeta: 4'h0,
        keySync: 4'h0,
        keyPrev: 4'h0,
        phase: IDLE,
        divCnt: 32'h0,
        slotCnt: 6'h0,
        bitIdx: 4'h0,
        frameCnt: 3'h0,
        frameWord: 12'h0,
        serialOut: 1'b0,
        txPower: 1'b0
    };

    localparam logic [31:0] SlotLast = 32'(SlotCycles - 1);

    // fixed nibble per key, lowest key wins on a tie
    function automatic logic [3:0] keyNibble(input logic [3:0] rise);
        logic [3:0] n;
        n = 4'h0;
        if (rise[3]) begin
            n = `NIBBLE_KEY4;
        end
        if (rise[2]) begin
            n = `NIBBLE_KEY3;
        end
        if (rise[1]) begin
            n = `NIBBLE_KEY2;
        end
        if (rise[0]) begin
            n = `NIBBLE_KEY1;
        end
        return n;
    endfunction

    // level of one slot of a data bit: '1' short high, '0' long high
    function automatic logic slotLevel(input logic bitVal, input logic [5:0] slot);
        logic lvl;
        lvl = 1'b0;
        if (slot == 6'h0) begin
            lvl = 1'b1;
        end else if (slot == 6'h1) begin
            lvl = ~bitVal;
        end
        return lvl;
    endfunction

    enc_state_t stateReg;
    enc_state_t stateNext;
    logic [3:0] keyRise;
    logic slotTick;
    logic curBit;

    assign keyRise = stateReg.keySync & ~stateReg.keyPrev;
    assign slotTick = (stateReg.divCnt == SlotLast);
    assign curBit = stateReg.frameWord[stateReg.bitIdx];

    always_comb begin
        stateNext = stateReg;
        // two-flop synchroniser for the button pins
        stateNext.keyMeta = {key_in_4, key_in_3, key_in_2, key_in_1};
        stateNext.keySync = stateReg.keyMeta;
        stateNext.keyPrev = stateReg.keySync;
        if (stateReg.phase != IDLE) begin
            if (slotTick) begin
                stateNext.divCnt = 32'h0;
            end else begin
                stateNext.divCnt = stateReg.divCnt + 32'h1;
            end
        end
        case (stateReg.phase)
            IDLE: begin
                stateNext.serialOut = 1'b0;
                stateNext.txPower = 1'b0;
                // only a fresh rise counts, so a held key cannot retrigger
                if (keyRise != 4'h0) begin
                    stateNext.frameWord = {keyNibble(keyRise), `DEVICE_ADDR};
                    stateNext.txPower = 1'b1;
                    stateNext.phase = PILOT;
                    stateNext.divCnt = 32'h0;
                    stateNext.slotCnt = 6'h0;
                    stateNext.frameCnt = 3'h0;
                end
            end
            PILOT: begin
                // silent gap ahead of each frame; power already up
                stateNext.serialOut = 1'b0;
                if (slotTick) begin
                    if (stateReg.slotCnt == `PILOT_SLOTS - 6'h1) begin
                        stateNext.slotCnt = 6'h0;
                        stateNext.phase = SYNC;
                        stateNext.serialOut = 1'b1;
                    end else begin
                        stateNext.slotCnt = stateReg.slotCnt + 6'h1;
                    end
                end
            end
            SYNC: begin
                if (slotTick) begin
                    stateNext.phase = DATA;
                    stateNext.bitIdx = 4'h0;
                    stateNext.slotCnt = 6'h0;
                    stateNext.serialOut = slotLevel(stateReg.frameWord[0], 6'h0);
                end
            end
            DATA: begin
                // keys are not looked at here, so mid-burst presses drop
                if (slotTick) begin
                    if (stateReg.slotCnt == `SLOTS_PER_BIT - 6'h1) begin
                        stateNext.slotCnt = 6'h0;
                        if (stateReg.bitIdx == 4'(`FRAME_BITS - 1)) begin
                            stateNext.bitIdx = 4'h0;
                            stateNext.serialOut = 1'b0;
                            if (stateReg.frameCnt == `FRAMES_PER_BURST - 3'h1) begin
                                stateNext.phase = IDLE;
                                stateNext.txPower = 1'b0;
                            end else begin
                                stateNext.frameCnt = stateReg.frameCnt + 3'h1;
                                stateNext.phase = PILOT;
                            end
                        end else begin
                            stateNext.bitIdx = stateReg.bitIdx + 4'h1;
                            stateNext.serialOut = slotLevel(
                                stateReg.frameWord[stateReg.bitIdx + 4'h1], 6'h0);
                        end
                    end else begin
                        stateNext.slotCnt = stateReg.slotCnt + 6'h1;
                        stateNext.serialOut = slotLevel(curBit, stateReg.slotCnt + 6'h1);
                    end
                end
            end
            default: begin
                stateNext = StateReset;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= StateReset;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign serialOut = stateReg.serialOut;
    assign radio_tx_power = stateReg.txPower;
    assign radio_rx_power = ~stateReg.txPower;

endmodule
`default_nettype wire

//--- test/remote_encoder_assertions.sv
// port checker for the remote encoder
`timescale 1ns/10ps
`default_nettype none
module remote_encoder_checker #(parameter int SlotCycles = 4) (
    input wire logic core_clk, rst_n,
    input wire logic key_in_1, key_in_2, key_in_3, key_in_4,
    input wire logic serialOut, radio_tx_power, radio_rx_power
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic anyKey;
    int unsigned hiCnt;
    assign anyKey = key_in_1 | key_in_2 | key_in_3 | key_in_4;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            hiCnt <= 0;
        else
            hiCnt <= radio_tx_power ? hiCnt + 1 : 0;
    end
    sequence s_pilot; !serialOut [*8]; endsequence
    sequence s_mark; serialOut [*4]; endsequence
    chk_rx_inverse: assert property (radio_rx_power == !radio_tx_power)
        else $error("rx power not inverse");
    chk_idle_low: assert property (!radio_tx_power |-> !serialOut)
        else $error("line high while idle");
    chk_tx_cause: assert property ($rose(radio_tx_power) |-> $past(anyKey, 3) || $past(anyKey, 4))
        else $error("burst without key");
    chk_pilot_low: assert property ($rose(radio_tx_power) |-> s_pilot)
        else $error("line not low after power up");
    chk_mark_width: assert property ($rose(serialOut) |-> s_mark)
        else $error("high slot too short");
    // bounds fit a four or five cycle slot only
    chk_mark_end: assert property ($rose(serialOut) |-> s_mark ##[0:8] !serialOut)
        else $error("high run too long");
    chk_burst_len: assert property ($fell(radio_tx_power) |-> hiCnt == 5 * 73 * SlotCycles)
        else $error("burst length wrong");
    chk_tx_hold: assert property ($rose(radio_tx_power) |=> radio_tx_power [*8])
        else $error("tx power dropped early");
endmodule
bind oneshot_four_key_remote_encoder remote_encoder_checker #(.SlotCycles(SlotCycles)) chk (
    .core_clk(core_clk), .rst_n(rst_n), .key_in_1(key_in_1), .key_in_2(key_in_2),
    .key_in_3(key_in_3), .key_in_4(key_in_4), .serialOut(serialOut),
    .radio_tx_power(radio_tx_power), .radio_rx_power(radio_rx_power));
`default_nettype wire

//--- test/rf_receiver_model.sv
// receiver model that decodes the serial line into frame words
`timescale 1ns/10ps
`default_nettype none
module rf_receiver_model #(parameter int Sc = 4) (
    input wire logic core_clk,
    input wire logic serialOut,
    output logic [11:0] word,
    output int frames
);
    int hiLen = 0;
    int loLen = 0;
    int nBits = 0;
    logic [11:0] sh;
    initial frames = 0;
    always @(posedge core_clk) begin
        if (serialOut) begin
            hiLen++;
        end else if (hiLen == 0) begin
            loLen++;
        end else begin
            // sync merges with the first bit's high slot
            if (loLen > 30 * Sc) begin
                nBits = 0;
                hiLen -= Sc;
            end
            sh = {hiLen == Sc, sh[11:1]};
            nBits++;
            if (nBits == 12) begin
                word <= sh;
                frames++;
            end
            hiLen = 0;
            loLen = 1;
        end
    end
endmodule
`default_nettype wire

//--- test/test_oneshot_four_key_remote_encoder.sv
// self-checking bench for the remote encoder
`timescale 1ns/10ps
`default_nettype none
`include "remote_encoder_consts.svh"
module test_oneshot_four_key_remote_encoder;
    localparam int Sc = 4;
    localparam int Burst = 5 * 73 * Sc;
    logic core_clk = 0;
    logic rst_n = 0;
    logic [3:0] keys = 4'h0;
    logic serialOut, radio_tx_power, radio_rx_power;
    logic [11:0] word;
    int frames, mismatches = 0, comparisons = 0;
    always #5 core_clk = ~core_clk;
    oneshot_four_key_remote_encoder #(.SlotCycles(Sc)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .key_in_1(keys[0]), .key_in_2(keys[1]), .key_in_3(keys[2]), .key_in_4(keys[3]),
        .serialOut(serialOut), .radio_tx_power(radio_tx_power), .radio_rx_power(radio_rx_power));
    rf_receiver_model #(.Sc(Sc)) rx (.core_clk(core_clk), .serialOut(serialOut), .word(word),
        .frames(frames));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic burst(input logic [3:0] press, input logic [3:0] nib);
        int f0;
        int n;
        f0 = frames;
        keys = press;
        for (n = 0; n < 10 && radio_tx_power !== 1'b1; n++)
            step(1);
        check(radio_rx_power, 1'b0);
        step(Burst - 2);
        check(radio_tx_power, 1'b1);
        for (n = 0; n < 10 && radio_tx_power !== 1'b0; n++)
            step(1);
        check(frames - f0, 5);
        check(word, {nib, `DEVICE_ADDR});
        keys = 4'h0;
        step(4);
        $display("burst %h done", press);
    endtask
    task automatic one_shot;
        keys = 4'h1;
        step(Burst / 2);
        keys = 4'h0;
        step(2);
        // re-press mid-burst must be dropped, not queued
        keys = 4'h2;
        step(Burst);
        check({radio_tx_power, serialOut}, 2'b00);
        keys = 4'h0;
        step(4);
        $display("one-shot done");
    endtask
    task automatic reset_mid;
        keys = 4'h8;
        step(Burst / 3);
        rst_n = 0;
        step(1);
        check({serialOut, radio_tx_power, radio_rx_power}, 3'b001);
        keys = 4'h0;
        step(2);
        rst_n = 1;
        step(2);
        $display("reset done");
    endtask
    initial begin
        step(6);
        rst_n = 1;
        step(2);
        for (int k = 0; k < 4; k++)
            burst(4'h1 << k, 4'h1 << k);
        burst(4'hf, 4'h1);
        one_shot;
        reset_mid;
        burst(4'h4, 4'h4);
        tally_and_finish;
    end
    initial begin
        repeat (12 * Burst) @(posedge core_clk);
        mismatches++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
